// file: hdl/fcrb_params.svh
// Constants of the fan controller input register bank: indices, fields, codes and timing.
`ifndef FCRB_PARAMS_SVH
`define FCRB_PARAMS_SVH

// ----------------------------------------------------------------
// Widths and sizes
// ----------------------------------------------------------------
`define FCRB_WORD_W 16
`define FCRB_NUM_DRV 20
`define FCRB_IDX_W 5
`define FCRB_DEPTH 32
`define FCRB_QTY_W 7
`define FCRB_BLINK_CNT_W 24

// ----------------------------------------------------------------
// Register indices (protocol address, register number minus one)
// ----------------------------------------------------------------
`define FCRB_IDX_KNOB 5'h00
`define FCRB_IDX_ORIGIN 5'h01
`define FCRB_IDX_INPUT 5'h02
`define FCRB_IDX_OUTPUT 5'h03
`define FCRB_IDX_INSTALL 5'h04
`define FCRB_IDX_DRV_FIRST 5'h0A
`define FCRB_IDX_DRV_LAST 5'h1D
`define FCRB_MAP_END 17'h0001E
`define FCRB_QTY_MAX 16'h007D

// ----------------------------------------------------------------
// Values, codes and field positions
// ----------------------------------------------------------------
`define FCRB_PERMILLE_MAX 16'h03E8
`define FCRB_EXC_ADDR 16'h0002
`define FCRB_EXC_QTY 16'h0003
`define FCRB_POS_SUMMARY 8
`define FCRB_INST_OK 3'h0
`define FCRB_INST_CFG 3'h1
`define FCRB_INST_NORESP 3'h2
`define FCRB_INST_WARN 3'h4
`define FCRB_INST_ERR 3'h6
`define FCRB_COL_GREEN 2'h0
`define FCRB_COL_BLUE 2'h1
`define FCRB_COL_YELLOW 2'h2
`define FCRB_COL_RED 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FCRB_CLK_HZ 20000000
`define FCRB_BLINK_HALF_MS 500
`define FCRB_BLINK_HALF_CYC ((`FCRB_CLK_HZ / 1000) * `FCRB_BLINK_HALF_MS)

`endif

// file: hdl/fcrb_pkg.sv
// Types of the fan controller input register bank.
`include "fcrb_params.svh"

package fcrb_pkg;

  // ----------------------------------------------------------------
  // Request engine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_LOAD, S_SEND} fcrb_state_t;

  typedef struct packed {
    fcrb_state_t state;
    logic [`FCRB_IDX_W-1:0] scan;
    logic [`FCRB_IDX_W-1:0] ptr;
    logic [`FCRB_QTY_W-1:0] left;
    logic [2:0] install;
    logic req_ready;
    logic rsp_valid;
    logic [`FCRB_WORD_W-1:0] rsp_data;
    logic rsp_exc;
    logic rsp_last;
  } fcrb_core_t;

  // ----------------------------------------------------------------
  // Lamp driver and image memory
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`FCRB_BLINK_CNT_W-1:0] cnt;
    logic phase;
    logic [3:0] lamp;
  } fcrb_lamp_t;

  typedef struct packed {
    logic [`FCRB_WORD_W-1:0] rd_data;
  } fcrb_ram_t;

endpackage : fcrb_pkg

// file: hdl/fcrb_image_ram.sv
// Image memory of the input registers, one write port and a registered read port.
`include "fcrb_params.svh"

module fcrb_image_ram
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic [`FCRB_IDX_W-1:0] wr_addr,
  input wire logic [`FCRB_WORD_W-1:0] wr_data,
  // Read port
  input wire logic [`FCRB_IDX_W-1:0] rd_addr,
  output logic [`FCRB_WORD_W-1:0] rd_data
);
  import fcrb_pkg::*;

  logic [`FCRB_WORD_W-1:0] mem [`FCRB_DEPTH];
  fcrb_ram_t q_r;
  fcrb_ram_t q_nxt;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Array has no reset; the scanner fills it within one sweep
  always_ff @(posedge clk)
  begin
    mem[wr_addr] <= wr_data;
  end

  // Read data from a register, old word on a same-address collision
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.rd_data = mem[rd_addr];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign rd_data = q_r.rd_data;

endmodule : fcrb_image_ram

// file: hdl/fcrb_lamp.sv
// Status lamp driver: colour from the installation code, steady or blinking.
`include "fcrb_params.svh"

module fcrb_lamp
#(
  parameter int BLINK_HALF_CYC = `FCRB_BLINK_HALF_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Installation code
  input wire logic [2:0] code,
  // Lamp, one bit per colour: green, blue, yellow, red
  output logic [3:0] lamp
);
  import fcrb_pkg::*;

  localparam logic [`FCRB_BLINK_CNT_W-1:0] HALF_LAST = `FCRB_BLINK_CNT_W'(BLINK_HALF_CYC - 1);

  fcrb_lamp_t q_r;
  fcrb_lamp_t q_nxt;

  // ----------------------------------------------------------------
  // Blink timer and colour select
  // ----------------------------------------------------------------
  always_comb
  begin
    q_nxt = q_r;
    if (q_r.cnt >= HALF_LAST)
    begin
      q_nxt.cnt = '0;
      q_nxt.phase = ~q_r.phase;
    end
    else
      q_nxt.cnt = q_r.cnt + 1'b1;
    // Upper code bits pick colour, low bit asks for blinking
    q_nxt.lamp = '0;
    q_nxt.lamp[code[2:1]] = ~code[0] | q_r.phase;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign lamp = q_r.lamp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_lamp_steady;
    @(posedge clk) disable iff (!rst_n)
    !code[0] |=> lamp[$past(code[2:1])];
  endproperty
  a_lamp_steady: assert property (p_lamp_steady) else $error("even code lamp not steady");

  property p_lamp_colour;
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> $onehot0(lamp) && ((lamp & ~(4'h1 << $past(code[2:1]))) == 4'h0);
  endproperty
  a_lamp_colour: assert property (p_lamp_colour) else $error("lamp shows wrong colour");

endmodule : fcrb_lamp

// file: hdl/fcrb_bank.sv
// Input register bank of the fan controller, answering read-input-registers requests.
`include "fcrb_params.svh"

module fcrb_bank
#(
  parameter int BLINK_HALF_CYC = `FCRB_BLINK_HALF_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Live process values
  input wire logic [`FCRB_WORD_W-1:0] knob_raw,
  input wire logic source_sel,
  input wire logic [`FCRB_WORD_W-1:0] override_value,
  input wire logic [`FCRB_WORD_W-1:0] output_raw,
  input wire logic cfg_needed,
  // Per-motor event flags
  input wire logic [`FCRB_NUM_DRV-1:0][5:0] drv_warn,
  input wire logic [`FCRB_NUM_DRV-1:0][6:0] drv_err,
  // Read request
  input wire logic req_valid,
  input wire logic [`FCRB_WORD_W-1:0] req_start,
  input wire logic [`FCRB_WORD_W-1:0] req_qty,
  output logic req_ready,
  // Read response
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [`FCRB_WORD_W-1:0] rsp_data,
  output logic rsp_exc,
  output logic rsp_last,
  // Status lamp
  output logic [3:0] lamp,
  output logic [2:0] install_code
);
  import fcrb_pkg::*;

  fcrb_core_t q_r;
  fcrb_core_t q_nxt;

  logic [`FCRB_NUM_DRV-1:0][`FCRB_WORD_W-1:0] drv_word;
  logic [`FCRB_NUM_DRV-1:0] drv_has_err;
  logic [`FCRB_NUM_DRV-1:0] drv_has_warn;
  logic [`FCRB_NUM_DRV-1:0] drv_no_resp;
  logic [`FCRB_WORD_W-1:0] knob_live;
  logic [`FCRB_WORD_W-1:0] input_live;
  logic [`FCRB_WORD_W-1:0] output_live;
  logic [`FCRB_WORD_W-1:0] origin_live;
  logic [2:0] install_live;
  logic [`FCRB_WORD_W-1:0] scan_value;
  logic [`FCRB_IDX_W-1:0] scan_drv;
  logic [`FCRB_WORD_W-1:0] ram_rdata;
  logic [`FCRB_WORD_W:0] req_end;
  logic qty_bad;
  logic addr_bad;
  logic take;
  logic err_many;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Saturate a per-mille quantity; raw sources may overshoot full scale
  function automatic logic [`FCRB_WORD_W-1:0] clamp_pm(input logic [`FCRB_WORD_W-1:0] v);
    clamp_pm = (v > `FCRB_PERMILLE_MAX) ? `FCRB_PERMILLE_MAX : v;
  endfunction : clamp_pm

  // True when two or more bits are set
  function automatic logic many(input logic [`FCRB_NUM_DRV-1:0] v);
    many = |(v & (v - 1'b1));
  endfunction : many

  // ----------------------------------------------------------------
  // Per-mille values and input origin
  // ----------------------------------------------------------------
  // Clamp before selection so the input value never exceeds full scale
  assign knob_live = clamp_pm(knob_raw);
  assign output_live = clamp_pm(output_raw);
  assign input_live = source_sel ? clamp_pm(override_value) : knob_live;
  assign origin_live = {{(`FCRB_WORD_W-1){1'b0}}, source_sel};

  // ----------------------------------------------------------------
  // Motor status words
  // ----------------------------------------------------------------
  // Word bit k-1 carries numbered bit k, so bit 1 lands on the LSB
  generate
    for (genvar i = 0; i < `FCRB_NUM_DRV; i++)
    begin : g_drv
      assign drv_word[i][2:0] = drv_warn[i][2:0];
      assign drv_word[i][4:3] = 2'h0;
      assign drv_word[i][7:5] = drv_warn[i][5:3];
      assign drv_word[i][`FCRB_POS_SUMMARY] = |drv_err[i];
      assign drv_word[i][15:9] = drv_err[i];
      assign drv_has_err[i] = drv_word[i][`FCRB_POS_SUMMARY];
      assign drv_has_warn[i] = |{drv_word[i][7:5], drv_word[i][2:1]};
      assign drv_no_resp[i] = drv_word[i][0];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Installation code
  // ----------------------------------------------------------------
  // Several motors in error, kept as a net so the checks can sample it
  assign err_many = many(drv_has_err);

  // Most severe condition wins; the low bit tells one motor from several
  always_comb
  begin
    if (|drv_has_err)
      install_live = `FCRB_INST_ERR | {2'h0, many(drv_has_err)};
    else if (|drv_has_warn)
      install_live = `FCRB_INST_WARN | {2'h0, many(drv_has_warn)};
    else if (|drv_no_resp)
      install_live = `FCRB_INST_NORESP | {2'h0, many(drv_no_resp)};
    else if (cfg_needed)
      install_live = `FCRB_INST_CFG;
    else
      install_live = `FCRB_INST_OK;
  end

  // ----------------------------------------------------------------
  // Image scanner
  // ----------------------------------------------------------------
  // One location refreshed per clock, so a word is at most a sweep old
  assign scan_drv = q_r.scan - `FCRB_IDX_DRV_FIRST;

  always_comb
  begin
    scan_value = '0;
    if (q_r.scan >= `FCRB_IDX_DRV_FIRST && q_r.scan <= `FCRB_IDX_DRV_LAST)
      scan_value = drv_word[scan_drv];
    else
    begin
      unique case (q_r.scan)
        `FCRB_IDX_KNOB: scan_value = knob_live;
        `FCRB_IDX_ORIGIN: scan_value = origin_live;
        `FCRB_IDX_INPUT: scan_value = input_live;
        `FCRB_IDX_OUTPUT: scan_value = output_live;
        `FCRB_IDX_INSTALL: scan_value = {13'h0000, q_r.install};
        default: scan_value = '0;
      endcase
    end
  end

  fcrb_image_ram u_ram
  (
    .clk(clk),
    .rst_n(rst_n),
    .wr_addr(q_r.scan),
    .wr_data(scan_value),
    .rd_addr(q_r.ptr),
    .rd_data(ram_rdata)
  );

  // ----------------------------------------------------------------
  // Request checks
  // ----------------------------------------------------------------
  // Quantity is judged before address, as the protocol orders them
  assign req_end = {1'b0, req_start} + {1'b0, req_qty};
  assign qty_bad = (req_qty == '0) || (req_qty > `FCRB_QTY_MAX);
  assign addr_bad = req_end > `FCRB_MAP_END;
  assign take = req_valid && q_r.req_ready;

  // ----------------------------------------------------------------
  // Request engine
  // ----------------------------------------------------------------
  // Reads only move the pointer; no register content changes on read
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.scan = q_r.scan + 1'b1;
    q_nxt.install = install_live;
    unique case (q_r.state)
      S_IDLE:
      begin
        if (take)
        begin
          q_nxt.req_ready = 1'b0;
          if (qty_bad || addr_bad)
          begin
            q_nxt.rsp_valid = 1'b1;
            q_nxt.rsp_exc = 1'b1;
            q_nxt.rsp_last = 1'b1;
            q_nxt.rsp_data = qty_bad ? `FCRB_EXC_QTY : `FCRB_EXC_ADDR;
            q_nxt.state = S_SEND;
          end
          else
          begin
            q_nxt.ptr = req_start[`FCRB_IDX_W-1:0];
            q_nxt.left = req_qty[`FCRB_QTY_W-1:0];
            q_nxt.state = S_FETCH;
          end
        end
      end
      S_FETCH:
        q_nxt.state = S_LOAD;
      S_LOAD:
      begin
        q_nxt.rsp_valid = 1'b1;
        q_nxt.rsp_exc = 1'b0;
        q_nxt.rsp_data = ram_rdata;
        q_nxt.rsp_last = (q_r.left == 7'h01);
        q_nxt.state = S_SEND;
      end
      S_SEND:
      begin
        if (rsp_ready)
        begin
          q_nxt.rsp_valid = 1'b0;
          if (q_r.rsp_last)
          begin
            q_nxt.rsp_last = 1'b0;
            q_nxt.rsp_exc = 1'b0;
            q_nxt.req_ready = 1'b1;
            q_nxt.state = S_IDLE;
          end
          else
          begin
            q_nxt.ptr = q_r.ptr + 1'b1;
            q_nxt.left = q_r.left - 1'b1;
            q_nxt.state = S_FETCH;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_r <= '0;
      q_r.state <= S_IDLE;
      q_r.req_ready <= 1'b1;
    end
    else
      q_r <= q_nxt;
  end

  // ----------------------------------------------------------------
  // Lamp
  // ----------------------------------------------------------------
  fcrb_lamp #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) u_lamp
  (
    .clk(clk),
    .rst_n(rst_n),
    .code(q_r.install),
    .lamp(lamp)
  );

  assign req_ready = q_r.req_ready;
  assign rsp_valid = q_r.rsp_valid;
  assign rsp_data = q_r.rsp_data;
  assign rsp_exc = q_r.rsp_exc;
  assign rsp_last = q_r.rsp_last;
  assign install_code = q_r.install;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_good_take;
    take && !qty_bad && !addr_bad;
  endsequence

  sequence s_first_word;
    ##3 rsp_valid && !rsp_exc;
  endsequence

  property p_reply;
    @(posedge clk) disable iff (!rst_n)
    s_good_take |-> s_first_word;
  endproperty
  a_reply: assert property (p_reply) else $error("no data word three cycles after request");

  property p_exception;
    @(posedge clk) disable iff (!rst_n)
    take && (qty_bad || addr_bad) |=> rsp_valid && rsp_exc && rsp_last && rsp_data[15:2] == 14'h0000;
  endproperty
  a_exception: assert property (p_exception) else $error("bad request not answered by exception");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last);
  endproperty
  a_hold: assert property (p_hold) else $error("response changed while stalled");

  property p_clamp;
    @(posedge clk) disable iff (!rst_n)
    knob_live <= `FCRB_PERMILLE_MAX && input_live <= `FCRB_PERMILLE_MAX && output_live <= `FCRB_PERMILLE_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("per-mille value above full scale");

  property p_source;
    @(posedge clk) disable iff (!rst_n)
    !source_sel |-> input_live == knob_live && origin_live == 16'h0000;
  endproperty
  a_source: assert property (p_source) else $error("knob source not followed");

  property p_install;
    @(posedge clk) disable iff (!rst_n)
    (|drv_has_err) |=> install_code[2:1] == 2'h3 && install_code[0] == $past(err_many);
  endproperty
  a_install: assert property (p_install) else $error("error code not reported");

  property p_healthy;
    @(posedge clk) disable iff (!rst_n)
    drv_warn == '0 && drv_err == '0 && !cfg_needed |=> install_code == 3'h0;
  endproperty
  a_healthy: assert property (p_healthy) else $error("healthy plant not reported OK");

  property p_words;
    @(posedge clk) disable iff (!rst_n)
    (q_r.scan >= `FCRB_IDX_DRV_FIRST && q_r.scan <= `FCRB_IDX_DRV_LAST) |->
      scan_value[4:3] == 2'h0 && scan_value[8] == (|scan_value[15:9]) && scan_value[15] == drv_err[scan_drv][6];
  endproperty
  a_words: assert property (p_words) else $error("motor word layout wrong");

  // No second request may slip in while an answer is still pending
  property p_busy;
    @(posedge clk) disable iff (!rst_n)
    rsp_valid |-> !req_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("request accepted while answer pending");

  property p_qty_first;
    @(posedge clk) disable iff (!rst_n)
    take && qty_bad |=> rsp_data == `FCRB_EXC_QTY;
  endproperty
  a_qty_first: assert property (p_qty_first) else $error("quantity fault not reported first");

  property p_ready_back;
    @(posedge clk) disable iff (!rst_n)
    rsp_valid && rsp_ready && rsp_last |=> req_ready && !rsp_valid;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("not ready after last word");

endmodule : fcrb_bank

// file: bench/fcrb_master.sv
// Read-input-registers master model for the bank's request and response ports.
`include "fcrb_params.svh"

module fcrb_master
(
  // Clock
  input wire logic clk,
  // Request
  output logic req_valid,
  output logic [`FCRB_WORD_W-1:0] req_start,
  output logic [`FCRB_WORD_W-1:0] req_qty,
  input wire logic req_ready,
  // Response
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire logic [`FCRB_WORD_W-1:0] rsp_data,
  input wire logic rsp_exc,
  input wire logic rsp_last
);
  timeunit 1ns;
  timeprecision 1ns;

  // Words of the last answer; word bit 0 is status bit 1
  logic [`FCRB_WORD_W-1:0] words [$];
  logic exc;
  int stall = 0;

  // Idle request lines show a pattern, never a stale request
  initial
  begin
    req_valid = 1'b0;
    req_start = 16'hA5A5;
    req_qty = 16'h5A5A;
    rsp_ready = 1'b1;
  end

  // One request held until taken, then words gathered up to the last
  task automatic read_regs(input logic [15:0] start, input logic [15:0] qty);
    int n;
    logic done;
    words.delete();
    done = 1'b0;
    n = 0;
    req_valid = 1'b1;
    req_start = start;
    req_qty = qty;
    while (req_ready !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    req_start = ~start;
    req_qty = ~qty;
    // Slow mode accepts one cycle in three; bounded so a hang ends
    while (!done && n < 400)
    begin
      rsp_ready = (stall == 0) || (n % 3 == 0);
      if (rsp_valid === 1'b1 && rsp_ready)
      begin
        words.push_back(rsp_data);
        exc = rsp_exc;
        done = rsp_last;
      end
      @(posedge clk);
      #1;
      n++;
    end
    rsp_ready = 1'b1;
  endtask : read_regs
endmodule : fcrb_master

// file: bench/fcrb_bank_tb.sv
// Self-checking testbench of the fan controller input register bank.
`include "fcrb_params.svh"

module fcrb_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fcrb_pkg::*;

  // Short blink half period keeps odd codes visible in a few cycles
  localparam int HALF = 4;

  logic clk, rst_n, source_sel, cfg_needed;
  logic [`FCRB_WORD_W-1:0] knob_raw, override_value, output_raw, req_start, req_qty, rsp_data;
  logic [`FCRB_NUM_DRV-1:0][5:0] drv_warn;
  logic [`FCRB_NUM_DRV-1:0][6:0] drv_err;
  logic req_valid, req_ready, rsp_valid, rsp_ready, rsp_exc, rsp_last;
  logic [3:0] lamp;
  logic [2:0] install_code;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;

  fcrb_bank #(.BLINK_HALF_CYC(HALF)) i_dut (.clk(clk), .rst_n(rst_n), .knob_raw(knob_raw),
    .source_sel(source_sel), .override_value(override_value), .output_raw(output_raw),
    .cfg_needed(cfg_needed), .drv_warn(drv_warn), .drv_err(drv_err), .req_valid(req_valid),
    .req_start(req_start), .req_qty(req_qty), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_exc(rsp_exc), .rsp_last(rsp_last),
    .lamp(lamp), .install_code(install_code));

  fcrb_master i_mst (.clk(clk), .req_valid(req_valid), .req_start(req_start), .req_qty(req_qty),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
    .rsp_exc(rsp_exc), .rsp_last(rsp_last));

  // ----------------------------------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Ceiling well above the fewer than one thousand cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      err_total++;
      $display("wrong value at %0t: run did not complete", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic check_w(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : check_w

  task automatic check_l(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: lamp %h, expected %h", $time, got, exp);
    end
  endtask : check_l

  // Snapshot may be 32 cycles stale, so wait past that
  task automatic settle();
    repeat (40) @(posedge clk);
    #1;
  endtask : settle

  task automatic test_end(input string name);
    $display("test %s done", name);
  endtask : test_end

  // Expected motor word: warnings low, summary bit, errors high
  function automatic logic [15:0] drv_word(input logic [5:0] w, input logic [6:0] e);
    return {e, |e, w[5:3], 2'b00, w[2:0]};
  endfunction : drv_word

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    int xs [6] = '{0, 0, 29, 30, 40, 0};
    int xq [6] = '{0, 126, 2, 1, 200, 125};
    int xc [6] = '{3, 3, 2, 2, 3, 2};
    logic [3:0] col;
    int off;
    rst_n = 1'b0;
    source_sel = 1'b0;
    cfg_needed = 1'b0;
    knob_raw = 16'h0064;
    override_value = 16'h01F4;
    output_raw = 16'h04B0;
    drv_warn = '0;
    drv_err = '0;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    settle();
    i_mst.read_regs(16'h0000, 16'h0005);
    check_w(16'(i_mst.words.size()), 16'h0005);
    check_w(i_mst.words[0], 16'h0064);
    check_w(i_mst.words[1], 16'h0000);
    check_w(i_mst.words[2], 16'h0064);
    check_w(i_mst.words[3], `FCRB_PERMILLE_MAX);
    check_w(i_mst.words[4], 16'h0000);
    i_mst.read_regs(16'h0005, 16'h0005);
    for (int k = 0; k < 5; k++)
      check_w(i_mst.words[k], 16'h0000);
    test_end("values");
    // Bus value overrides, just above and below full scale, slow master
    knob_raw = 16'h03E9;
    override_value = 16'h03E7;
    source_sel = 1'b1;
    i_mst.stall = 1;
    settle();
    i_mst.read_regs(16'h0000, 16'h0003);
    check_w(i_mst.words[0], `FCRB_PERMILLE_MAX);
    check_w(i_mst.words[1], 16'h0001);
    check_w(i_mst.words[2], 16'h03E7);
    i_mst.stall = 0;
    test_end("override");
    // Motor patterns; last motor left healthy
    for (int k = 0; k < `FCRB_NUM_DRV - 1; k++)
    begin
      drv_warn[k] = (k < 6) ? 6'(1 << k) : 6'(k * 11);
      drv_err[k] = (k < 7) ? 7'(1 << k) : (k[0] ? 7'h00 : 7'(k * 37));
    end
    settle();
    i_mst.read_regs(16'h000A, 16'h0014);
    check_w({15'h0000, i_mst.exc}, 16'h0000);
    for (int k = 0; k < `FCRB_NUM_DRV; k++)
      check_w(i_mst.words[k], drv_word(drv_warn[k], drv_err[k]));
    test_end("motors");
    // Each installation code, from single and multiple conditions
    for (int c = 0; c < 8; c++)
    begin
      drv_warn = '0;
      drv_err = '0;
      cfg_needed = (c == 1);
      drv_warn[3][0] = c inside {2, 3};
      drv_warn[8][0] = (c == 3);
      drv_warn[3][1] = c inside {4, 5};
      drv_warn[8][4] = (c == 5);
      drv_err[3][0] = (c >= 6);
      drv_err[8][6] = (c == 7);
      settle();
      check_w(16'(install_code), 16'(c));
      i_mst.read_regs(16'h0004, 16'h0001);
      check_w(i_mst.words[0], 16'(c));
      col = 4'(1 << (c / 2));
      off = 0;
      repeat (2 * HALF + 2)
      begin
        @(posedge clk);
        #1;
        off += (lamp === 4'h0);
        check_l((c % 2 == 1 && lamp === 4'h0) ? col : lamp, col);
      end
      check_w(16'(off > 0), 16'(c % 2));
    end
    test_end("install");
    // Refused requests, quantity check ahead of address check
    for (int i = 0; i < 6; i++)
    begin
      i_mst.read_regs(16'(xs[i]), 16'(xq[i]));
      check_w({15'h0000, i_mst.exc}, 16'h0001);
      check_w(i_mst.words[0], 16'(xc[i]));
    end
    test_end("exceptions");
    // Reset in mid-run clears outputs, then reads resume
    rst_n = 1'b0;
    #5;
    check_l(lamp, 4'h0);
    check_w(16'(install_code), 16'h0000);
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    settle();
    i_mst.read_regs(16'h0004, 16'h0001);
    check_w(i_mst.words[0], 16'h0007);
    test_end("reset");
    tally_and_finish();
  end
endmodule : fcrb_bank_tb
